// *** rtl/xbs_pkg.sv ***
// Constants and types shared by the serial port 0 and address pin multiplexer
package xbs_pkg;

    localparam int unsigned REG_ADDR_W     = 8;
    localparam int unsigned REG_DATA_W     = 16;
    localparam logic [7:0]  EXT_BUS_SEL_OFS = 8'h00;
    localparam logic [15:0] EXT_BUS_SEL_RST = 16'h0000;
    localparam logic [15:0] EXT_BUS_SEL_RW_MASK = 16'h033F;

    localparam int unsigned ROUTE_LSB      = 8;
    localparam int unsigned ROUTE_MSB      = 9;
    localparam int unsigned RSVD_LSB       = 6;
    localparam int unsigned RSVD_MSB       = 7;
    localparam int unsigned ADDR_SEL_LSB   = 0;
    localparam int unsigned ADDR_SEL_MSB   = 5;

    localparam int unsigned ADDR_LINE15_BIT = 0;
    localparam int unsigned ADDR_LINE16_BIT = 1;
    localparam int unsigned ADDR_LINE17_BIT = 2;
    localparam int unsigned ADDR_LINE18_BIT = 3;
    localparam int unsigned ADDR_LINE19_BIT = 4;
    localparam int unsigned ADDR_LINE20_BIT = 5;

    localparam int unsigned SP0_PIN_CNT    = 6;
    localparam int unsigned ADDR_PIN_CNT   = 6;
    localparam int unsigned PAD_CNT        = 12;
    localparam int unsigned ADDR_PAD_BASE  = 6;
    localparam logic [2:0]  AUDIO_PIN_CNT  = 3'h4;

    typedef enum logic [1:0] {
        ROUTE_CARD  = 2'b00,
        ROUTE_AUDIO = 2'b01,
        ROUTE_GPIO  = 2'b10,
        ROUTE_RSVD  = 2'b11
    } xbs_route_t;

    typedef enum logic [1:0] {
        OWN_NONE  = 2'b00,
        OWN_CARD  = 2'b01,
        OWN_AUDIO = 2'b10,
        OWN_GPIO  = 2'b11
    } xbs_owner_t;

    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } xbs_pad6_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } xbs_pad4_t;

    typedef struct packed {
        xbs_route_t serial_port0_route_sel;
        logic [5:0] addr_line_pin_sel;
    } xbs_cfg_t;

    typedef struct packed {
        xbs_cfg_t    cfg;
        logic [15:0] rdata;
        xbs_pad6_t   sp0_pad;
        xbs_pad6_t   adr_pad;
        logic [5:0]  card_in;
        logic [3:0]  audio_in;
        logic [5:0]  gpl_in;
        logic [5:0]  gph_in;
        logic [11:0] sync1;
        logic [11:0] sync2;
        logic [11:0] sync3;
        logic [11:0] pad_in;
    } xbs_state_t;

    localparam xbs_state_t STATE_RST = '0;

endpackage

// *** rtl/xbs_pin_mux.sv ***
// Serial port 0 and upper address pin multiplexer with its selection register
//
// What this block and its software do
// RL1 - Route code 00 puts all six memory card port 0 signals on the six pins.
// RL2 - Route code 01 puts four audio port signals and general pins 5:4 on the pins.
// RL3 - Route code 10 puts general pins 5:0 on the pins; code 11 is reserved.
// RL4 - Register bits 7 and 6 are read-only zero and ignore writes.
// RL5 - Bit 5 selects address line 20 when 0, general pin 26 when 1.
// RL6 - Bit 4 selects address line 19 when 0, general pin 25 when 1.
// RL7 - Bit 3 selects address line 18 when 0, general pin 24 when 1.
// RL8 - Bit 2 selects address line 17 when 0, general pin 23 when 1.
// RL9 - Bit 1 selects address line 16 when 0, general pin 22 when 1.
// RL10 - Bit 0 selects address line 15 when 0, general pin 21 when 1.
// RL11 - Software resets every affected peripheral after changing pin routing.
// RL12 - Only the selected function drives a pin or sees its input; others see zero.
`timescale 1ns/1ps
`default_nettype none

module xbs_pin_mux (
    input  wire logic               ref_clk_i,
    input  wire logic               srst_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [15:0]        reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [15:0]        reg_rdata_o,
    input  wire logic [5:0]         sp0_pad_in_i,
    output var xbs_pkg::xbs_pad6_t  sp0_pad_o,
    input  wire logic [5:0]         adr_pad_in_i,
    output var xbs_pkg::xbs_pad6_t  adr_pad_o,
    input  wire xbs_pkg::xbs_pad6_t memory_card_port0_drv_i,
    output logic      [5:0]         memory_card_port0_in_o,
    input  wire xbs_pkg::xbs_pad4_t audio_serial_port0_drv_i,
    output logic      [3:0]         audio_serial_port0_in_o,
    input  wire xbs_pkg::xbs_pad6_t general_pins_low_six_drv_i,
    output logic      [5:0]         general_pins_low_six_in_o,
    input  wire xbs_pkg::xbs_pad6_t general_pins_high_six_drv_i,
    output logic      [5:0]         general_pins_high_six_in_o,
    input  wire logic [5:0]         ext_mem_addr_i
);

    xbs_pkg::xbs_state_t st;
    xbs_pkg::xbs_state_t next_st;

    // Which function owns a serial port 0 pin under a given route code
    function automatic xbs_pkg::xbs_owner_t sp0_owner(
        input xbs_pkg::xbs_route_t route,
        input logic [2:0]          pin
    );
        xbs_pkg::xbs_owner_t own;
        own = xbs_pkg::OWN_NONE;
        case (route)
            xbs_pkg::ROUTE_CARD: begin
                own = xbs_pkg::OWN_CARD;
            end
            xbs_pkg::ROUTE_AUDIO: begin
                own = (pin < xbs_pkg::AUDIO_PIN_CNT) ? xbs_pkg::OWN_AUDIO : xbs_pkg::OWN_GPIO;
            end
            xbs_pkg::ROUTE_GPIO: begin
                own = xbs_pkg::OWN_GPIO;
            end
            default: begin
                own = xbs_pkg::OWN_NONE;
            end
        endcase
        return own;
    endfunction

    // Read image of the selection register; reserved and absent bits read zero
    function automatic logic [15:0] reg_image(input xbs_pkg::xbs_cfg_t cfg);
        logic [15:0] img;
        img = xbs_pkg::EXT_BUS_SEL_RST;
        img[xbs_pkg::ROUTE_MSB:xbs_pkg::ROUTE_LSB] = cfg.serial_port0_route_sel;
        img[xbs_pkg::ADDR_SEL_MSB:xbs_pkg::ADDR_SEL_LSB] = cfg.addr_line_pin_sel;
        return img;
    endfunction

    always_comb begin
        xbs_pkg::xbs_owner_t own;
        own = xbs_pkg::OWN_NONE;
        next_st = st;

        // Pin inputs: three stages, a change is taken once stages two and three agree
        next_st.sync1 = {adr_pad_in_i, sp0_pad_in_i};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < xbs_pkg::PAD_CNT; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.pad_in[i] = st.sync3[i];
            end
        end

        // Register write; bits 7:6 and 15:10 are not stored
        if (reg_wr_i && (reg_addr_i == xbs_pkg::EXT_BUS_SEL_OFS)) begin
            next_st.cfg.serial_port0_route_sel =
                xbs_pkg::xbs_route_t'(reg_wdata_i[xbs_pkg::ROUTE_MSB:xbs_pkg::ROUTE_LSB]);
            next_st.cfg.addr_line_pin_sel =
                reg_wdata_i[xbs_pkg::ADDR_SEL_MSB:xbs_pkg::ADDR_SEL_LSB]; // RL4
        end

        // Read data stands only in the cycle after the read strobe
        next_st.rdata = 16'h0000;
        if (reg_rd_i && (reg_addr_i == xbs_pkg::EXT_BUS_SEL_OFS)) begin
            next_st.rdata = reg_image(st.cfg); // RL4
        end

        // Unselected functions see zero and never drive
        next_st.card_in  = 6'h00; // RL12
        next_st.audio_in = 4'h0;
        next_st.gpl_in   = 6'h00;
        next_st.gph_in   = 6'h00;
        next_st.sp0_pad  = '0;

        for (int i = 0; i < xbs_pkg::SP0_PIN_CNT; i++) begin
            own = sp0_owner(st.cfg.serial_port0_route_sel, 3'(i));
            case (own)
                xbs_pkg::OWN_CARD: begin
                    next_st.sp0_pad.out[i] = memory_card_port0_drv_i.out[i]; // RL1
                    next_st.sp0_pad.oe[i]  = memory_card_port0_drv_i.oe[i];
                    next_st.card_in[i]     = st.pad_in[i];
                end
                xbs_pkg::OWN_AUDIO: begin
                    next_st.sp0_pad.out[i]     = audio_serial_port0_drv_i.out[2'(i)]; // RL2
                    next_st.sp0_pad.oe[i]      = audio_serial_port0_drv_i.oe[2'(i)];
                    next_st.audio_in[2'(i)]    = st.pad_in[i];
                end
                xbs_pkg::OWN_GPIO: begin
                    next_st.sp0_pad.out[i] = general_pins_low_six_drv_i.out[i]; // RL3
                    next_st.sp0_pad.oe[i]  = general_pins_low_six_drv_i.oe[i];
                    next_st.gpl_in[i]      = st.pad_in[i];
                end
                default: begin
                    next_st.sp0_pad.out[i] = 1'b0; // RL12
                    next_st.sp0_pad.oe[i]  = 1'b0;
                end
            endcase
        end

        // Upper address pins: 0 gives the memory address line, 1 the general pin
        for (int i = 0; i < xbs_pkg::ADDR_PIN_CNT; i++) begin // RL6 RL7 RL8 RL9
            if (st.cfg.addr_line_pin_sel[i]) begin
                next_st.adr_pad.out[i] = general_pins_high_six_drv_i.out[i]; // RL5
                next_st.adr_pad.oe[i]  = general_pins_high_six_drv_i.oe[i];
                next_st.gph_in[i]      = st.pad_in[xbs_pkg::ADDR_PAD_BASE + i]; // RL12
            end else begin
                next_st.adr_pad.out[i] = ext_mem_addr_i[i]; // RL10
                next_st.adr_pad.oe[i]  = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st <= xbs_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o                 = st.rdata;
    assign sp0_pad_o                   = st.sp0_pad;
    assign adr_pad_o                   = st.adr_pad;
    assign memory_card_port0_in_o      = st.card_in;
    assign audio_serial_port0_in_o     = st.audio_in;
    assign general_pins_low_six_in_o   = st.gpl_in;
    assign general_pins_high_six_in_o  = st.gph_in;

    // Checks
    logic [5:0] sp0_pad_q;
    logic [5:0] adr_pad_q;
    logic       sel_wr;
    logic       sel_rd;
    logic [5:0] gp_sel;

    assign gp_sel    = st.cfg.addr_line_pin_sel;
    assign sp0_pad_q = st.pad_in[5:0];
    assign adr_pad_q = st.pad_in[11:6];
    assign sel_wr    = reg_wr_i && (reg_addr_i == xbs_pkg::EXT_BUS_SEL_OFS);
    assign sel_rd    = reg_rd_i && (reg_addr_i == xbs_pkg::EXT_BUS_SEL_OFS);

    default clocking cb @(posedge ref_clk_i);
    endclocking

    default disable iff (srst_i);

    property p_card_route;
        !srst_i && (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_CARD)
        |=> (sp0_pad_o.out == $past(memory_card_port0_drv_i.out))
            && (sp0_pad_o.oe == $past(memory_card_port0_drv_i.oe))
            && (memory_card_port0_in_o == $past(sp0_pad_q))
            && (audio_serial_port0_in_o == 4'h0)
            && (general_pins_low_six_in_o == 6'h00);
    endproperty
    a_card_route: assert property (p_card_route) // RL1
        else $error("card route does not own serial port 0 pins");

    property p_audio_route;
        (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_AUDIO)
        |=> (sp0_pad_o.out[3:0] == $past(audio_serial_port0_drv_i.out))
            && (sp0_pad_o.oe[3:0] == $past(audio_serial_port0_drv_i.oe))
            && (sp0_pad_o.out[5:4] == $past(general_pins_low_six_drv_i.out[5:4]))
            && (audio_serial_port0_in_o == $past(sp0_pad_q[3:0]))
            && (general_pins_low_six_in_o[3:0] == 4'h0)
            && (memory_card_port0_in_o == 6'h00);
    endproperty
    a_audio_route: assert property (p_audio_route) // RL2
        else $error("audio route does not split pins four and two");

    property p_gpio_route;
        (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_GPIO)
        |=> (sp0_pad_o.out == $past(general_pins_low_six_drv_i.out))
            && (sp0_pad_o.oe == $past(general_pins_low_six_drv_i.oe))
            && (general_pins_low_six_in_o == $past(sp0_pad_q))
            && (memory_card_port0_in_o == 6'h00)
            && (audio_serial_port0_in_o == 4'h0);
    endproperty
    a_gpio_route: assert property (p_gpio_route) // RL3
        else $error("general pin route does not own serial port 0 pins");

    property p_rsvd_route_quiet;
        (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_RSVD)
        |=> (sp0_pad_o.oe == 6'h00) && (sp0_pad_o.out == 6'h00)
            && (memory_card_port0_in_o == 6'h00) && (audio_serial_port0_in_o == 4'h0)
            && (general_pins_low_six_in_o == 6'h00);
    endproperty
    a_rsvd_route_quiet: assert property (p_rsvd_route_quiet) // RL12
        else $error("reserved route drives a pin");

    property p_write_readback;
        sel_wr ##1 sel_rd
        |=> (reg_rdata_o == ($past(reg_wdata_i, 2) & xbs_pkg::EXT_BUS_SEL_RW_MASK));
    endproperty
    a_write_readback: assert property (p_write_readback) // RL4
        else $error("readback differs from written value under the mask");

    property p_rdata_only_after_read;
        !sel_rd |=> (reg_rdata_o == 16'h0000);
    endproperty
    a_rdata_only_after_read: assert property (p_rdata_only_after_read)
        else $error("read data present without a read");

    property p_addr_line20;
        !srst_i && (st.cfg.addr_line_pin_sel[xbs_pkg::ADDR_LINE20_BIT] == 1'b0)
        |=> adr_pad_o.oe[5] && (adr_pad_o.out[5] == $past(ext_mem_addr_i[5]))
            && (general_pins_high_six_in_o[5] == 1'b0);
    endproperty
    a_addr_line20: assert property (p_addr_line20) // RL5
        else $error("pin of address line 20 misrouted");

    property p_addr_line19;
        (st.cfg.addr_line_pin_sel[xbs_pkg::ADDR_LINE19_BIT] == 1'b1)
        |=> (adr_pad_o.out[4] == $past(general_pins_high_six_drv_i.out[4]))
            && (adr_pad_o.oe[4] == $past(general_pins_high_six_drv_i.oe[4]))
            && (general_pins_high_six_in_o[4] == $past(adr_pad_q[4]));
    endproperty
    a_addr_line19: assert property (p_addr_line19) // RL6
        else $error("pin of general pin 25 misrouted");

    property p_addr_line18;
        !srst_i && (st.cfg.addr_line_pin_sel[xbs_pkg::ADDR_LINE18_BIT] == 1'b0)
        |=> adr_pad_o.oe[3] && (adr_pad_o.out[3] == $past(ext_mem_addr_i[3]));
    endproperty
    a_addr_line18: assert property (p_addr_line18) // RL7
        else $error("pin of address line 18 misrouted");

    property p_addr_line17;
        (st.cfg.addr_line_pin_sel[xbs_pkg::ADDR_LINE17_BIT] == 1'b1)
        |=> (adr_pad_o.out[2] == $past(general_pins_high_six_drv_i.out[2]))
            && (general_pins_high_six_in_o[2] == $past(adr_pad_q[2]));
    endproperty
    a_addr_line17: assert property (p_addr_line17) // RL8
        else $error("pin of general pin 23 misrouted");

    property p_addr_line16;
        !srst_i && (st.cfg.addr_line_pin_sel[xbs_pkg::ADDR_LINE16_BIT] == 1'b0)
        |=> adr_pad_o.oe[1] && (adr_pad_o.out[1] == $past(ext_mem_addr_i[1]));
    endproperty
    a_addr_line16: assert property (p_addr_line16) // RL9
        else $error("pin of address line 16 misrouted");

    property p_addr_line15;
        (st.cfg.addr_line_pin_sel[xbs_pkg::ADDR_LINE15_BIT] == 1'b1)
        |=> (adr_pad_o.oe[0] == $past(general_pins_high_six_drv_i.oe[0]))
            && (general_pins_high_six_in_o[0] == $past(adr_pad_q[0]));
    endproperty
    a_addr_line15: assert property (p_addr_line15) // RL10
        else $error("pin of general pin 21 misrouted");

    property p_pad_input_latency;
        ((st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_GPIO) && sp0_pad_in_i[0])[*5]
        |=> general_pins_low_six_in_o[0];
    endproperty
    a_pad_input_latency: assert property (p_pad_input_latency) // RL12
        else $error("steady pin level not seen after five cycles");

    property p_rsvd_bits_read_zero;
        (reg_rdata_o & ~xbs_pkg::EXT_BUS_SEL_RW_MASK) == 16'h0000;
    endproperty
    a_rsvd_bits_read_zero: assert property (p_rsvd_bits_read_zero) // RL4
        else $error("reserved or absent register bits read non-zero");

    property p_cfg_holds;
        !srst_i && !sel_wr |=> $stable(st.cfg);
    endproperty
    a_cfg_holds: assert property (p_cfg_holds)
        else $error("selection register changed without a write");

    property p_audio_upper_pins;
        !srst_i && (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_AUDIO)
        |=> (sp0_pad_o.oe[5:4] == $past(general_pins_low_six_drv_i.oe[5:4]))
            && (general_pins_low_six_in_o[5:4] == $past(sp0_pad_q[5:4]));
    endproperty
    a_audio_upper_pins: assert property (p_audio_upper_pins) // RL2
        else $error("general pins 5 and 4 not carried in audio route");

    property p_gph_in_gated;
        !srst_i |=> ((general_pins_high_six_in_o & ~$past(gp_sel)) == 6'h00);
    endproperty
    a_gph_in_gated: assert property (p_gph_in_gated) // RL12
        else $error("address-mode pin passed to a general pin input");

    property p_addr_mem_drive;
        !srst_i
        |=> ((adr_pad_o.oe | $past(gp_sel)) == 6'h3F)
            && (((adr_pad_o.out ^ $past(ext_mem_addr_i)) & ~$past(gp_sel)) == 6'h00);
    endproperty
    a_addr_mem_drive: assert property (p_addr_mem_drive) // RL5 RL6 RL7 RL8 RL9 RL10
        else $error("address-mode pin does not drive its address line");

    property p_addr_gp_drive;
        !srst_i
        |=> (((adr_pad_o.out ^ $past(general_pins_high_six_drv_i.out))
                & $past(gp_sel)) == 6'h00)
            && (((adr_pad_o.oe ^ $past(general_pins_high_six_drv_i.oe))
                & $past(gp_sel)) == 6'h00);
    endproperty
    a_addr_gp_drive: assert property (p_addr_gp_drive) // RL5 RL6 RL7 RL8 RL9 RL10
        else $error("general-mode pin does not follow its general pin drive");

    c_card_mode: cover property (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_CARD);
    c_audio_mode: cover property (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_AUDIO);
    c_gpio_mode: cover property (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_GPIO);
    c_rsvd_mode: cover property (st.cfg.serial_port0_route_sel == xbs_pkg::ROUTE_RSVD);
    c_addr_to_gpio: cover property (sel_wr ##1 (adr_pad_o.oe == 6'h00));

endmodule

`default_nettype wire

// *** dv/xbs_pin_mux_test.sv ***
// Self-checking testbench for the serial port 0 and address pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module xbs_pin_mux_test;

    typedef struct packed {
        xbs_pkg::xbs_pad6_t sp0;
        xbs_pkg::xbs_pad6_t adr;
        logic [5:0]         card;
        logic [3:0]         aud;
        logic [5:0]         gpl;
        logic [5:0]         gph;
    } xbs_pin_exp_t;

    logic               ref_clk_i;
    logic               srst_i;
    logic [7:0]         reg_addr_i;
    logic [15:0]        reg_wdata_i;
    logic               reg_wr_i;
    logic               reg_rd_i;
    logic [15:0]        reg_rdata_o;
    logic [5:0]         sp0_in;
    logic [5:0]         adr_in;
    logic [5:0]         ext_addr;
    xbs_pkg::xbs_pad6_t sp0_pad_o;
    xbs_pkg::xbs_pad6_t adr_pad_o;
    xbs_pkg::xbs_pad6_t card_drv;
    xbs_pkg::xbs_pad6_t gpl_drv;
    xbs_pkg::xbs_pad6_t gph_drv;
    xbs_pkg::xbs_pad4_t aud_drv;
    xbs_pin_exp_t       got;
    logic [5:0]         card_in;
    logic [3:0]         aud_in;
    logic [5:0]         gpl_in;
    logic [5:0]         gph_in;
    logic [15:0]        shadow;
    logic [15:0]        rd_q[$];
    xbs_pin_exp_t       pin_q[$];
    logic               rd_seen = 1'b0;
    logic               pin_req;
    int                 failures;
    int                 num_checks;
    int                 cycles;
    int                 k;
    int                 n;
    int unsigned        seed_dummy;

    xbs_pin_mux dut (
        .ref_clk_i                   (ref_clk_i),
        .srst_i                      (srst_i),
        .reg_addr_i                  (reg_addr_i),
        .reg_wdata_i                 (reg_wdata_i),
        .reg_wr_i                    (reg_wr_i),
        .reg_rd_i                    (reg_rd_i),
        .reg_rdata_o                 (reg_rdata_o),
        .sp0_pad_in_i                (sp0_in),
        .sp0_pad_o                   (sp0_pad_o),
        .adr_pad_in_i                (adr_in),
        .adr_pad_o                   (adr_pad_o),
        .memory_card_port0_drv_i     (card_drv),
        .memory_card_port0_in_o      (card_in),
        .audio_serial_port0_drv_i    (aud_drv),
        .audio_serial_port0_in_o     (aud_in),
        .general_pins_low_six_drv_i  (gpl_drv),
        .general_pins_low_six_in_o   (gpl_in),
        .general_pins_high_six_drv_i (gph_drv),
        .general_pins_high_six_in_o  (gph_in),
        .ext_mem_addr_i              (ext_addr)
    );

    assign got = {sp0_pad_o, adr_pad_o, card_in, aud_in, gpl_in, gph_in};

    always #2.5 ref_clk_i = ~ref_clk_i;

    // Expected pin routing for a register value and the present stimulus
    function automatic xbs_pin_exp_t model(input logic [15:0] r);
        xbs_pin_exp_t e;
        e = '0;
        case (r[9:8])
            2'b00: begin
                e.sp0  = card_drv;
                e.card = sp0_in;
            end
            2'b01: begin
                e.sp0.out = {gpl_drv.out[5:4], aud_drv.out};
                e.sp0.oe  = {gpl_drv.oe[5:4], aud_drv.oe};
                e.aud     = sp0_in[3:0];
                e.gpl     = {sp0_in[5:4], 4'h0};
            end
            2'b10: begin
                e.sp0 = gpl_drv;
                e.gpl = sp0_in;
            end
            default: begin
            end
        endcase
        for (int i = 0; i < 6; i++) begin
            e.adr.out[i] = r[i] ? gph_drv.out[i] : ext_addr[i];
            e.adr.oe[i]  = r[i] ? gph_drv.oe[i] : 1'b1;
            e.gph[i]     = r[i] ? adr_in[i] : 1'b0;
        end
        return e;
    endfunction

    task automatic cmp_rd(input logic [15:0] exp);
        num_checks++;
        if (reg_rdata_o !== exp) begin
            failures++;
            $display("BAD %0t read data %h expected %h", $time, reg_rdata_o, exp);
        end
    endtask

    task automatic cmp_pins(input xbs_pin_exp_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t pins %h expected %h cfg %h", $time, got, exp, shadow);
        end
    endtask

    // One bus cycle; strobes stay as set until bus_idle or the next cycle
    task automatic bus_op(input logic wr, input logic rd, input logic [7:0] a,
                          input logic [15:0] d, input logic [15:0] exp);
        reg_wr_i    <= wr;
        reg_rd_i    <= rd;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        if (wr && a == xbs_pkg::EXT_BUS_SEL_OFS) begin
            shadow = d & xbs_pkg::EXT_BUS_SEL_RW_MASK;
        end
        if (rd) begin
            rd_q.push_back(exp);
        end
        @(posedge ref_clk_i);
    endtask

    task automatic bus_idle();
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
    endtask

    task automatic rand_pins();
        logic [63:0] rnd;
        rnd = {$urandom, $urandom};
        card_drv <= rnd[11:0];
        aud_drv  <= rnd[19:12];
        gpl_drv  <= rnd[31:20];
        gph_drv  <= rnd[43:32];
        ext_addr <= rnd[49:44];
        sp0_in   <= rnd[55:50];
        adr_in   <= rnd[61:56];
    endtask

    // Inputs settle through the synchroniser before the check is queued
    task automatic pin_chk();
        repeat (8) @(posedge ref_clk_i);
        pin_q.push_back(model(shadow));
        pin_req <= 1'b1;
        @(posedge ref_clk_i);
        pin_req <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Monitor: read data stands in the cycle after the strobe only
    always @(posedge ref_clk_i) begin
        if (rd_seen && rd_q.size() > 0) begin
            cmp_rd(rd_q.pop_front());
        end
        if (pin_req && pin_q.size() > 0) begin
            cmp_pins(pin_q.pop_front());
        end
        rd_seen <= reg_rd_i;
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        ref_clk_i   = 1'b0;
        srst_i      = 1'b1;
        reg_addr_i  = 8'h00;
        reg_wdata_i = 16'h0000;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        {card_drv, gpl_drv, gph_drv, aud_drv} = '0;
        {sp0_in, adr_in, ext_addr} = '0;
        pin_req     = 1'b0;
        shadow      = xbs_pkg::EXT_BUS_SEL_RST;
        failures    = 0;
        num_checks  = 0;
        cycles      = 0;
        seed_dummy  = $urandom(8);
        repeat (5) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rand_pins();
        bus_op(1'b0, 1'b1, 8'h00, 16'h0000, xbs_pkg::EXT_BUS_SEL_RST);
        bus_idle();
        pin_chk();
        // Every route code, with random pin selects and random reserved bits
        for (k = 0; k < 4; k++) begin
            for (n = 0; n < 6; n++) begin
                rand_pins();
                bus_op(1'b1, 1'b0, 8'h00, 16'(($urandom & 32'hfcff) | (k << 8)), 16'h0000);
                bus_op(1'b0, 1'b1, 8'h00, 16'h0000, shadow);
                // Routed functions restart from fresh drive values after a routing change
                rand_pins();
                bus_idle();
                pin_chk();
                rand_pins();
                pin_chk();
            end
        end
        // Unmapped addresses: writes ignored, reads give zero
        for (n = 1; n < 6; n++) begin
            bus_op(1'b1, 1'b0, 8'(n * 37), 16'hffff, 16'h0000);
            bus_op(1'b0, 1'b1, 8'(n * 37), 16'h0000, 16'h0000);
            bus_op(1'b0, 1'b1, 8'h00, 16'h0000, shadow);
        end
        bus_idle();
        pin_chk();
        // Reset in mid-run returns the register to its reset value
        bus_op(1'b1, 1'b0, 8'h00, 16'h02ff, 16'h0000);
        bus_idle();
        srst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        shadow = xbs_pkg::EXT_BUS_SEL_RST;
        bus_op(1'b0, 1'b1, 8'h00, 16'h0000, xbs_pkg::EXT_BUS_SEL_RST);
        bus_idle();
        pin_chk();
        repeat (4) @(posedge ref_clk_i);
        report_and_stop();
    end

endmodule

`default_nettype wire
